/* hdl/i2cm_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Byte addresses on a 16-bit APB address bus.
// Notes:   Definitions only.
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH
`define I2CM_ADR_CTRL  16'h3800
`define I2CM_ADR_TGT   16'h3804
`define I2CM_ADR_DC    16'h3810
`define I2CM_ADR_HI    16'h3814
`define I2CM_ADR_STS   16'h3830
`define I2CM_ADR_CLR   16'h3834
`define I2CM_ADR_IEN   16'h3838
`define I2CM_ADR_AUX   16'h383C
`define I2CM_ADR_IFEN  16'h386C
`define I2CM_RST_CTRL  7'h65
`define I2CM_CTRL_WMSK 7'h6F
`define I2CM_RST_TGT   7'h55
`define I2CM_RST_HI    16'h0064
`define I2CM_HI_MIN    16'h0006
`define I2CM_HI_ADD    17'h00008
`define I2CM_LO_ADD    17'h00001
`define I2CM_STD_LO    16'h0076
`define I2CM_FST_HI    16'h000F
`define I2CM_FST_LO    16'h0021
`define I2CM_CLK_NS    5
`define I2CM_TI2C_NS   100
`define I2CM_DIV ((`I2CM_TI2C_NS + `I2CM_CLK_NS - 1) / `I2CM_CLK_NS)
`define I2CM_SPD_FST   2'h2
`define I2CM_STB       8'h01
`define I2CM_B_MEN     0
`define I2CM_B_RST     5
`define I2CM_B_CMD     8
`define I2CM_S_ABORT   0
`define I2CM_S_DONE    1
`define I2CM_S_NACK    2
`define I2CM_A_STOP    0
`define I2CM_A_SB      1
`endif

/* hdl/i2cm_pkg.sv */
// Purpose: Types shared by the I2C master register slice.
// Assumes: Constants live in i2cm_cfg.svh.
// Notes:   None.
package i2cm_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } i2cm_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } i2cm_apb_rsp_t;
    typedef enum logic [3:0] {
        st_idle, st_sta, st_stb, st_low, st_high,
        st_hold, st_rslo, st_splo, st_sphi
    } i2cm_state_t;
    typedef struct packed {
        i2cm_state_t st;
        logic [16:0] cnt;
        logic [4:0]  bidx;
        logic [4:0]  blast;
        logic [17:0] sh;
        logic        nack;
        logic [6:0]  ctrl;
        logic [6:0]  tgt;
        logic [7:0]  dat;
        logic        cmd_rd;
        logic        pend;
        logic        stop_req;
        logic        sb_req;
        logic        sb_act;
        logic [15:0] hi;
        logic        ifen;
        logic [2:0]  sts;
        logic [2:0]  ien;
        logic [7:0]  div;
        logic        tick;
        logic        scl_oe;
        logic        sda_oe;
        logic        ack;
        logic        slverr;
        logic [31:0] rdata;
        logic [1:0]  sda_sy;
    } i2cm_q_t;
endpackage : i2cm_pkg

/* hdl/i2cm_top.sv */
// Purpose: I2C master configuration registers with a byte engine.
// Assumes: APB slave, 200 MHz clock, open-drain SCL and SDA pins.
// Notes:   Operation
// Operation
// - Restart bit zero forbids repeated starts; one allows them.
// - Without restarts every byte is its own transfer, stop then start.
// - Without restarts a start-byte request is dropped and abort is set.
// - Speed 01 is standard, 10 is fast, 00 and 11 are reserved.
// - Speed field changes only while the interface is disabled.
// - Master enable resets to one and changes only while disabled.
// - Target address writes are dropped while the interface is enabled.
// - Low seven target bits form the address phase of every transfer.
// - Command bit written zero requests a write, one a read.
// - Write byte is given before transfer; read byte is returned there.
// - Standard high count writes count only while interface disabled.
// - A standard high count below six is stored as six.
// - Standard SCL high phase lasts high count plus eight I2C clocks.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "i2cm_cfg.svh"

module i2cm_top (
    // Clock and reset.
    input  wire logic                    clk_sys_i,
    input  wire logic                    reset_n_i,
    // APB slave.
    input  wire i2cm_pkg::i2cm_apb_req_t apb_req_i,
    output      i2cm_pkg::i2cm_apb_rsp_t apb_rsp_o,
    // I2C pins.
    input  wire logic                    sda_i,
    output      logic                    sda_o,
    output      logic                    sda_oe_o,
    output      logic                    scl_o,
    output      logic                    scl_oe_o,
    // Interrupt.
    output      logic                    irq_o
);

    localparam logic [7:0] DIV_M1 = 8'(`I2CM_DIV - 1);

    i2cm_pkg::i2cm_q_t q_r;
    i2cm_pkg::i2cm_q_t q_nxt;
    logic              setup;
    logic              wr;
    logic              adv;
    logic              fast;
    logic              smp;
    logic              nk;
    logic              fin;
    logic              acc_dc;
    logic [16:0]       hi_ld;
    logic [16:0]       lo_ld;

    ////////////////////////////////////////////////////////////////////////
    // Loads the shift register for a start byte or an address and data.
    function automatic i2cm_pkg::i2cm_q_t f_launch(
        input i2cm_pkg::i2cm_q_t s,
        input logic              sb
    );
        i2cm_pkg::i2cm_q_t r;
        r = s;
        if (sb) begin
            r.sh     = {`I2CM_STB, 10'h3FF};
            r.blast  = 5'h08;
            r.sb_act = 1'b1;
            r.sb_req = 1'b0;
        end else begin
            r.sh    = {s.tgt, s.cmd_rd, 1'b1,
                       s.cmd_rd ? 8'hFF : s.dat, 1'b1};
            r.blast = 5'h11;
            r.pend  = 1'b0;
        end
        r.bidx = 5'h00;
        r.nack = 1'b0;
        return r;
    endfunction : f_launch

    ////////////////////////////////////////////////////////////////////////
    // Bus strobes and phase lengths.
    assign setup  = apb_req_i.psel & ~apb_req_i.penable;
    assign wr     = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite
                    & q_r.ack;
    assign adv    = q_r.tick & (q_r.cnt == 17'h00000);
    assign fast   = q_r.ctrl[2:1] == `I2CM_SPD_FST;
    assign smp    = q_r.sda_sy[1];
    assign acc_dc = ~q_r.pend & ((q_r.st == i2cm_pkg::st_idle)
                    | (q_r.st == i2cm_pkg::st_hold));
    assign hi_ld  = (fast ? {1'b0, `I2CM_FST_HI} : {1'b0, q_r.hi})
                    + `I2CM_HI_ADD - 17'h00001;
    assign lo_ld  = (fast ? {1'b0, `I2CM_FST_LO} : {1'b0, `I2CM_STD_LO})
                    + `I2CM_LO_ADD - 17'h00001;
    assign nk     = ~q_r.sb_act & smp & ((q_r.bidx == 5'h08)
                    | ((q_r.bidx == 5'h11) & ~q_r.cmd_rd));
    assign fin    = (q_r.bidx == q_r.blast) | nk;

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        q_nxt        = q_r;
        q_nxt.sda_sy = {q_r.sda_sy[0], sda_i};
        q_nxt.tick   = q_r.div == DIV_M1;
        q_nxt.div    = q_nxt.tick ? 8'h00 : q_r.div + 8'h01;
        q_nxt.ack    = setup;
        if (q_r.tick && q_r.cnt != 17'h00000) begin
            q_nxt.cnt = q_r.cnt - 17'h00001;
        end
        if (setup) begin
            q_nxt.slverr = 1'b0;
            q_nxt.rdata  = '0;
            case (apb_req_i.paddr)
                `I2CM_ADR_CTRL: q_nxt.rdata[6:0]  = q_r.ctrl;
                `I2CM_ADR_TGT:  q_nxt.rdata[6:0]  = q_r.tgt;
                `I2CM_ADR_DC:   q_nxt.rdata[7:0]  = q_r.dat;
                `I2CM_ADR_HI:   q_nxt.rdata[15:0] = q_r.hi;
                `I2CM_ADR_IFEN: q_nxt.rdata[0]    = q_r.ifen;
                `I2CM_ADR_STS:  q_nxt.rdata[2:0]  = q_r.sts;
                `I2CM_ADR_CLR:  q_nxt.rdata[2:0]  = 3'h0;
                `I2CM_ADR_IEN:  q_nxt.rdata[2:0]  = q_r.ien;
                `I2CM_ADR_AUX:  q_nxt.rdata[2:0]  = {~acc_dc,
                                    q_r.sb_req, q_r.stop_req};
                default:        q_nxt.slverr      = 1'b1;
            endcase
        end
        if (wr) begin
            case (apb_req_i.paddr)
                `I2CM_ADR_CTRL: begin
                    if (!q_r.ifen) begin
                        q_nxt.ctrl = apb_req_i.pwdata[6:0]
                                     & `I2CM_CTRL_WMSK;
                    end
                end
                `I2CM_ADR_TGT: begin
                    if (!q_r.ifen) begin
                        q_nxt.tgt = apb_req_i.pwdata[6:0];
                    end
                end
                `I2CM_ADR_DC: begin
                    if (acc_dc) begin
                        q_nxt.dat    = apb_req_i.pwdata[7:0];
                        q_nxt.cmd_rd = apb_req_i.pwdata[`I2CM_B_CMD];
                        q_nxt.pend   = 1'b1;
                    end
                end
                `I2CM_ADR_HI: begin
                    if (!q_r.ifen) begin
                        q_nxt.hi = (apb_req_i.pwdata[15:0] < `I2CM_HI_MIN)
                                   ? `I2CM_HI_MIN
                                   : apb_req_i.pwdata[15:0];
                    end
                end
                `I2CM_ADR_IFEN: q_nxt.ifen = apb_req_i.pwdata[0];
                `I2CM_ADR_CLR:  q_nxt.sts  = q_r.sts
                                             & ~apb_req_i.pwdata[2:0];
                `I2CM_ADR_IEN:  q_nxt.ien  = apb_req_i.pwdata[2:0];
                `I2CM_ADR_AUX: begin
                    q_nxt.stop_req = q_r.stop_req
                                     | apb_req_i.pwdata[`I2CM_A_STOP];
                    q_nxt.sb_req   = q_r.sb_req
                                     | apb_req_i.pwdata[`I2CM_A_SB];
                end
                default: ;
            endcase
        end
        case (q_r.st)
            i2cm_pkg::st_idle: begin
                q_nxt.stop_req = 1'b0;
                if (q_r.ifen && q_r.ctrl[`I2CM_B_MEN]) begin
                    if (q_r.sb_req && !q_r.ctrl[`I2CM_B_RST]) begin
                        q_nxt.sb_req = 1'b0;
                        q_nxt.sts[`I2CM_S_ABORT] = 1'b1;
                    end else if (q_r.sb_req || q_r.pend) begin
                        q_nxt     = f_launch(q_nxt, q_r.sb_req);
                        q_nxt.st  = i2cm_pkg::st_stb;
                        q_nxt.cnt = hi_ld;
                    end
                end
            end
            i2cm_pkg::st_hold: begin
                if (!q_r.ifen || q_r.stop_req) begin
                    q_nxt.st       = i2cm_pkg::st_splo;
                    q_nxt.cnt      = lo_ld;
                    q_nxt.stop_req = 1'b0;
                end else if (q_r.sb_req || q_r.pend) begin
                    q_nxt     = f_launch(q_nxt, q_r.sb_req);
                    q_nxt.st  = i2cm_pkg::st_rslo;
                    q_nxt.cnt = lo_ld;
                end
            end
            i2cm_pkg::st_rslo: begin
                if (adv) begin
                    q_nxt.st  = i2cm_pkg::st_sta;
                    q_nxt.cnt = hi_ld;
                end
            end
            i2cm_pkg::st_sta: begin
                if (adv) begin
                    q_nxt.st  = i2cm_pkg::st_stb;
                    q_nxt.cnt = hi_ld;
                end
            end
            i2cm_pkg::st_stb: begin
                if (adv) begin
                    q_nxt.st  = i2cm_pkg::st_low;
                    q_nxt.cnt = lo_ld;
                end
            end
            i2cm_pkg::st_low: begin
                if (adv) begin
                    q_nxt.st  = i2cm_pkg::st_high;
                    q_nxt.cnt = hi_ld;
                end
            end
            i2cm_pkg::st_high: begin
                if (adv) begin
                    q_nxt.cnt = lo_ld;
                    if (q_r.cmd_rd && !q_r.sb_act && q_r.bidx > 5'h08
                        && q_r.bidx < 5'h11) begin
                        q_nxt.dat = {q_r.dat[6:0], smp};
                    end
                    if (nk) begin
                        q_nxt.nack = 1'b1;
                        q_nxt.sts[`I2CM_S_NACK] = 1'b1;
                    end
                    if (fin) begin
                        q_nxt.sb_act = 1'b0;
                        q_nxt.sts[`I2CM_S_DONE] = 1'b1;
                        if (q_r.ctrl[`I2CM_B_RST] && !q_r.stop_req
                            && q_r.ifen && !nk) begin
                            q_nxt.st = i2cm_pkg::st_hold;
                        end else begin
                            q_nxt.st = i2cm_pkg::st_splo;
                        end
                    end else begin
                        q_nxt.st   = i2cm_pkg::st_low;
                        q_nxt.bidx = q_r.bidx + 5'h01;
                        q_nxt.sh   = {q_r.sh[16:0], 1'b1};
                    end
                end
            end
            i2cm_pkg::st_splo: begin
                if (adv) begin
                    q_nxt.st  = i2cm_pkg::st_sphi;
                    q_nxt.cnt = hi_ld;
                end
            end
            i2cm_pkg::st_sphi: begin
                if (adv) begin
                    q_nxt.st = i2cm_pkg::st_idle;
                end
            end
            default: q_nxt.st = i2cm_pkg::st_idle;
        endcase
        case (q_nxt.st)
            i2cm_pkg::st_low, i2cm_pkg::st_high: begin
                q_nxt.scl_oe = q_nxt.st == i2cm_pkg::st_low;
                q_nxt.sda_oe = (q_r.st == q_nxt.st) ? ~q_nxt.sh[17]
                                                    : q_r.sda_oe;
            end
            i2cm_pkg::st_hold, i2cm_pkg::st_rslo: begin
                q_nxt.scl_oe = 1'b1;
                q_nxt.sda_oe = (q_r.st == i2cm_pkg::st_high) & q_r.sda_oe;
            end
            i2cm_pkg::st_splo: begin
                q_nxt.scl_oe = 1'b1;
                q_nxt.sda_oe = (q_r.st != i2cm_pkg::st_high) | q_r.sda_oe;
            end
            i2cm_pkg::st_stb, i2cm_pkg::st_sphi: begin
                q_nxt.scl_oe = 1'b0;
                q_nxt.sda_oe = 1'b1;
            end
            default: begin
                q_nxt.scl_oe = 1'b0;
                q_nxt.sda_oe = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q_r      <= '0;
            q_r.ctrl <= `I2CM_RST_CTRL;
            q_r.tgt  <= `I2CM_RST_TGT;
            q_r.hi   <= `I2CM_RST_HI;
        end else begin
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign apb_rsp_o.prdata  = q_r.rdata;
    assign apb_rsp_o.pready  = apb_req_i.psel & apb_req_i.penable & q_r.ack;
    assign apb_rsp_o.pslverr = apb_rsp_o.pready & q_r.slverr;
    assign sda_o             = 1'b0;
    assign scl_o             = 1'b0;
    assign sda_oe_o          = q_r.sda_oe;
    assign scl_oe_o          = q_r.scl_oe;
    assign irq_o             = |(q_r.sts & q_r.ien);

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_last_high;
        q_r.st == i2cm_pkg::st_high && adv && fin && !nk;
    endsequence
    sequence s_wr_locked(logic [15:0] a);
        wr && apb_req_i.paddr == a && q_r.ifen;
    endsequence

    property p_restart_gate;
        q_r.st == i2cm_pkg::st_rslo |-> q_r.ctrl[`I2CM_B_RST];
    endproperty
    a_restart_gate: assert property (p_restart_gate)
        else $error("Repeated start issued while restarts are off.");

    property p_split;
        s_last_high ##0 !q_r.ctrl[`I2CM_B_RST]
            |=> q_r.st == i2cm_pkg::st_splo ##1 q_r.sda_oe && q_r.scl_oe;
    endproperty
    a_split: assert property (p_split)
        else $error("Transfer not closed by a stop without restarts.");

    property p_abort;
        q_r.st == i2cm_pkg::st_idle && q_r.sb_req && q_r.ifen
            && q_r.ctrl[`I2CM_B_MEN] && !q_r.ctrl[`I2CM_B_RST]
            |=> q_r.sts[`I2CM_S_ABORT] && q_r.st == i2cm_pkg::st_idle;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Start byte not aborted without restarts.");

    property p_spd_lock;
        s_wr_locked(`I2CM_ADR_CTRL) |=> $stable(q_r.ctrl[2:1]);
    endproperty
    a_spd_lock: assert property (p_spd_lock)
        else $error("Speed field changed while enabled.");

    property p_men_lock;
        s_wr_locked(`I2CM_ADR_CTRL) |=> $stable(q_r.ctrl[`I2CM_B_MEN]);
    endproperty
    a_men_lock: assert property (p_men_lock)
        else $error("Master enable changed while enabled.");

    property p_tgt_lock;
        s_wr_locked(`I2CM_ADR_TGT) |=> $stable(q_r.tgt);
    endproperty
    a_tgt_lock: assert property (p_tgt_lock)
        else $error("Target address changed while enabled.");

    property p_addr;
        q_r.st == i2cm_pkg::st_stb && $past(q_r.st) != i2cm_pkg::st_stb
            && !q_r.sb_act |-> q_r.sh[17:11] == q_r.tgt;
    endproperty
    a_addr: assert property (p_addr)
        else $error("Address phase does not carry the target address.");

    property p_cmd;
        wr && apb_req_i.paddr == `I2CM_ADR_DC && acc_dc
            |=> q_r.pend && q_r.cmd_rd == $past(apb_req_i.pwdata[8]);
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("Command bit not taken from the data write.");

    property p_rx;
        q_r.st == i2cm_pkg::st_high && adv && q_r.cmd_rd && !q_r.sb_act
            && q_r.bidx == 5'h10 |=> q_r.dat[0] == $past(smp);
    endproperty
    a_rx: assert property (p_rx)
        else $error("Received bit not stored in the data field.");

    property p_hi_lock;
        s_wr_locked(`I2CM_ADR_HI) |=> $stable(q_r.hi);
    endproperty
    a_hi_lock: assert property (p_hi_lock)
        else $error("High count changed while enabled.");

    property p_clamp;
        wr && apb_req_i.paddr == `I2CM_ADR_HI && !q_r.ifen
            && apb_req_i.pwdata[15:0] < 16'h0006 |=> q_r.hi == 16'h0006;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("Small high count not raised to six.");

    property p_hi_len;
        q_r.st == i2cm_pkg::st_high && $past(q_r.st) != i2cm_pkg::st_high
            && !fast |-> q_r.cnt == {1'b0, q_r.hi} + 17'h00007;
    endproperty
    a_hi_len: assert property (p_hi_len)
        else $error("Standard high phase not count plus eight.");

endmodule : i2cm_top

/* sim/i2cm_slave.sv */
// Purpose: Behavioural I2C slave for the register slice bench.
// Assumes: Open-drain wires with pull-ups, no clock stretching.
// Notes:   Acks address and written data, serves one fixed read byte.
`timescale 1ns/1ps
module i2cm_slave #(
    parameter logic [7:0] RD_BYTE = 8'hA5
) (
    // Bus wires.
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    // Pull-down request and observations.
    output      logic       pull_o,
    output      logic [7:0] addr_o,
    output      logic [7:0] data_o,
    output      int         starts_o,
    output      int         stops_o
);
    int         bit_n = 0;
    int         ph    = 2;
    logic [7:0] sh;
    initial begin
        pull_o   = 1'b0;
        starts_o = 0;
        stops_o  = 0;
    end
    always @(negedge sda_i) if (scl_i === 1'b1) begin
        bit_n = 0;
        ph    = 0;
        starts_o++;
    end
    always @(posedge sda_i) if (scl_i === 1'b1 && starts_o > stops_o) begin
        ph = 2;
        stops_o++;
    end
    always @(posedge scl_i) begin
        if (bit_n < 8) sh = {sh[6:0], sda_i};
        bit_n++;
        if (bit_n == 8 && ph == 0) addr_o = sh;
        if (bit_n == 8 && ph == 1) data_o = sh;
        if (bit_n == 9) begin
            bit_n = 0;
            ph    = (ph == 0) ? 1 : 2;
        end
    end
    // Read bytes go out MSB first; the ack slot is released afterwards.
    always @(negedge scl_i) begin
        if (ph == 1 && addr_o[0])
            pull_o = bit_n < 8 && !RD_BYTE[7 - bit_n];
        else
            pull_o = (bit_n == 8 && ph < 2);
    end
endmodule : i2cm_slave

/* sim/i2cm_top_test.sv */
// Purpose: Self-checking bench for the I2C master register slice.
// Assumes: APB master tasks and one slave model on open-drain wires.
// Notes:   Standard high count is six to keep the phases short.
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2cm_top_test;
    logic                    clk_sys_i;
    logic                    reset_n_i;
    i2cm_pkg::i2cm_apb_req_t req;
    i2cm_pkg::i2cm_apb_rsp_t rsp;
    logic                    sda_oe, scl_oe, irq, pull, scl, sda;
    logic [7:0]              s_addr, s_data;
    int                      starts, stops;
    int                      mismatches = 0;
    int                      samples_checked = 0;
    int                      hi_cnt = 0;
    int                      hi_len = 0;
    logic [31:0]             rd;
    logic                    err;

    assign scl = ~scl_oe;
    assign sda = ~sda_oe & ~pull;

    i2cm_top uut (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .apb_req_i (req),
        .apb_rsp_o (rsp),
        .sda_i     (sda),
        .sda_o     (),
        .sda_oe_o  (sda_oe),
        .scl_o     (),
        .scl_oe_o  (scl_oe),
        .irq_o     (irq)
    );
    i2cm_slave slv (
        .scl_i    (scl),
        .sda_i    (sda),
        .pull_o   (pull),
        .addr_o   (s_addr),
        .data_o   (s_data),
        .starts_o (starts),
        .stops_o  (stops)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Length of the last finished SCL high phase, in clocks.
    always @(posedge clk_sys_i) begin
        if (scl === 1'b1) hi_cnt <= hi_cnt + 1;
        else begin
            if (hi_cnt != 0) hi_len <= hi_cnt;
            hi_cnt <= 0;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        do @(posedge clk_sys_i); while (rsp.pready !== 1'b1);
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic wait_done;
        do apb(1'b0, `I2CM_ADR_STS, 32'h0); while (rd[1] !== 1'b1);
        do apb(1'b0, `I2CM_ADR_AUX, 32'h0); while (rd[2] !== 1'b0);
    endtask : wait_done
    task automatic irq_chk(input logic exp);
        @(negedge clk_sys_i);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_chk
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    initial begin
        req       = '0;
        reset_n_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rchk(`I2CM_ADR_CTRL, 32'h65);
        rchk(`I2CM_ADR_TGT, 32'h55);
        rchk(`I2CM_ADR_HI, 32'h64);
        rchk(`I2CM_ADR_DC, 32'h0);
        rchk(16'h3808, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(`I2CM_ADR_HI, 32'h3);
        rchk(`I2CM_ADR_HI, 32'h6);
        wr(`I2CM_ADR_HI, 32'h6);
        wr(`I2CM_ADR_TGT, 32'h3A);
        wr(`I2CM_ADR_CTRL, 32'h43);
        wr(`I2CM_ADR_IEN, 32'h2);
        wr(`I2CM_ADR_IFEN, 32'h1);
        wr(`I2CM_ADR_TGT, 32'h11);
        rchk(`I2CM_ADR_TGT, 32'h3A);
        wr(`I2CM_ADR_CTRL, 32'h45);
        rchk(`I2CM_ADR_CTRL, 32'h43);
        wr(`I2CM_ADR_HI, 32'h9);
        rchk(`I2CM_ADR_HI, 32'h6);
        wr(`I2CM_ADR_DC, 32'hC3);
        wait_done();
        chk(s_addr, 8'h74);
        chk(s_data, 8'hC3);
        chk(stops, 1);
        chk(hi_len, 280);
        irq_chk(1'b1);
        wr(`I2CM_ADR_IEN, 32'h0);
        irq_chk(1'b0);
        wr(`I2CM_ADR_IEN, 32'h3);
        wr(`I2CM_ADR_CLR, 32'h2);
        rchk(`I2CM_ADR_STS, 32'h0);
        irq_chk(1'b0);
        wr(`I2CM_ADR_AUX, 32'h2);
        rchk(`I2CM_ADR_STS, 32'h1);
        irq_chk(1'b1);
        chk(starts, 1);
        wr(`I2CM_ADR_CLR, 32'h1);
        wr(`I2CM_ADR_IFEN, 32'h0);
        wr(`I2CM_ADR_CTRL, 32'h45);
        rchk(`I2CM_ADR_CTRL, 32'h45);
        wr(`I2CM_ADR_IFEN, 32'h1);
        wr(`I2CM_ADR_DC, 32'h100);
        wait_done();
        chk(s_addr, 8'h75);
        rchk(`I2CM_ADR_DC, 32'hA5);
        chk(hi_len, 460);
        chk(stops, 2);
        print_verdict();
    end
    initial begin
        repeat (95000) @(posedge clk_sys_i);
        mismatches++;
        print_verdict();
    end
endmodule : i2cm_top_test
